// ### cfi_can_node.sv
// Behavioural model of the CAN side that feeds events, levels and the reported mode.
`timescale 1ns/100ps
module cfi_can_node (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] req_mode,
  output logic [3:0] ev,
  output logic [1:0] pend,
  output logic [2:0] cur_mode,
  output logic [4:0] msg_index
);
  int lag = 1;
  int cnt = 0;
  // All outputs start defined so the block never sees an unknown.
  initial begin
    ev = 4'h0;
    pend = 2'h0;
    cur_mode = 3'h4;
    msg_index = 5'h00;
  end
  // The reported mode trails the request by lag+1 cycles, as a slow controller core would.
  always @(posedge clk) begin
    if (!nrst || cur_mode == req_mode) begin
      cnt <= 0;
      cur_mode <= nrst ? cur_mode : 3'h4;
    end else if (cnt >= lag) begin
      cur_mode <= req_mode;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // One-cycle pulse: bit 3 wake, 2 bus error, 1 system error, 0 overflow.
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask : pulse
endmodule : cfi_can_node

// ### cfi_pkg.sv
// Package with register map, field layout and types for the CAN flag and filter block.
package cfi_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FLAGS = 8'h04;
  localparam logic [7:0] OFF_FLT4 = 8'h08;
  localparam logic [7:0] OFF_FLT5 = 8'h0c;
  localparam logic [7:0] OFF_IEN = 8'h10;
  localparam logic [7:0] OFF_ICLR = 8'h14;
  localparam logic [7:0] OFF_FIDX = 8'h18;
  // Event flag positions.
  localparam int B_TX = 0;
  localparam int B_RX = 1;
  localparam int B_TMR = 2;
  localparam int B_MOD = 3;
  localparam int B_OVF = 11;
  localparam int B_SERR = 12;
  localparam int B_CERR = 13;
  localparam int B_WAKE = 14;
  localparam logic [15:0] FLAG_MASK = 16'h780f;
  localparam logic [15:0] SW_CLR_MASK = 16'h380c;
  // Control register fields.
  localparam int B_ON = 15;
  localparam int MODE_LO = 0;
  localparam logic [2:0] MODE_RST = 3'h4;
  // Filter half layout: enable, mask select, FIFO select.
  localparam int F_EN = 7;
  localparam int F_MSEL_LO = 5;
  localparam int F_FSEL_LO = 0;
  localparam int HALF = 8;
  localparam int TMR_W = 16;
  typedef struct packed {
    logic en;
    logic [1:0] msel;
    logic [4:0] fsel;
  } cfi_filt_s;
  typedef struct packed {
    logic wake;
    logic bus_err;
    logic sys_err;
    logic rx_ovf;
    logic rx_pend;
    logic tx_pend;
  } cfi_evt_s;
  typedef enum logic [1:0] {
    ST_ADDR = 2'b00,
    ST_DATA = 2'b01
  } cfi_bus_e;
endpackage : cfi_pkg

// ### cfi_top.sv
// CAN event flags, filter control for filters 16/17/20/21 and the AHB-Lite register slave.
// Notes on behaviour
// - Bus wake-up activity sets the wake flag, bit 14; otherwise it reads zero.
// - Any CAN bus error sets the bus error flag, bit 13.
// - A system bus fault such as an illegal address sets flag bit 12.
// - A message lost to a full receive buffer sets overflow flag bit 11.
// - Reported mode becoming equal to requested mode sets mode change flag bit 3.
// - Timestamp timer wrap sets the timer overflow flag, bit 2.
// - Receive pending, bit 1, follows any waiting receive buffer event.
// - Transmit pending, bit 0, follows any waiting transmit buffer event.
// - Flag bits 10 to 4 always read zero.
// - The sticky wake flag ignores software clears; only switching the module off clears it.
// - Filter enables sit at bit 15 and bit 7 of each filter register.
// - Two-bit mask select per filter at bits 14-13 and 6-5.
// - Five-bit FIFO select per filter at bits 12-8 and 4-0.
// - Mask and FIFO fields change only while that filter is disabled.
// - Filters 16/17 in group four, 20/21 in group five, higher filter upper byte.
// - The message index reads next slot to fill or next message to send.
//
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module cfi_top (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic WAKE_ACT,
  input wire logic BUS_ERR,
  input wire logic SYS_ERR,
  input wire logic RX_OVF,
  input wire logic RX_PEND,
  input wire logic TX_PEND,
  input wire logic [2:0] CURRENT_OPERATING_MODE,
  input wire logic [4:0] FIFO_MESSAGE_INDEX,
  output logic [2:0] REQUESTED_OPERATING_MODE,
  output logic MODULE_ON,
  output logic [31:0] FILTER_CTRL4,
  output logic [31:0] FILTER_CTRL5,
  output logic IRQ
);
  logic [15:0] flags_r, flags_nxt;
  logic [15:0] ien_r, ien_nxt;
  logic [15:0] flt4_r, flt4_nxt, flt5_r, flt5_nxt;
  logic on_r, on_nxt;
  logic [2:0] req_r, req_nxt;
  logic [2:0] mode_prev_r;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt;
  logic ill_r, ill_nxt;
  cfi_pkg::cfi_bus_e st_r, st_nxt;
  cfi_pkg::cfi_evt_s evt;
  logic tmr_wrap;
  logic addr_ok;
  logic mode_hit;

  assign evt = '{wake: WAKE_ACT, bus_err: BUS_ERR, sys_err: SYS_ERR, rx_ovf: RX_OVF,
                 rx_pend: RX_PEND, tx_pend: TX_PEND};

  // The timer runs only while the module is on.
  cfi_tstamp #(.W(cfi_pkg::TMR_W)) u_tmr (
    .clk(CLK),
    .nrst(NRST),
    .run(on_r),
    .count(),
    .wrap(tmr_wrap)
  );

  // Decides whether an offset is a mapped register.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == cfi_pkg::OFF_CTRL) || (a == cfi_pkg::OFF_FLAGS) || (a == cfi_pkg::OFF_FLT4) ||
             (a == cfi_pkg::OFF_FLT5) || (a == cfi_pkg::OFF_IEN) || (a == cfi_pkg::OFF_ICLR) ||
             (a == cfi_pkg::OFF_FIDX);
  endfunction : mapped

  // Applies a write to a pair of filters; each half's mask and FIFO fields only change while its filter is disabled, its enable bit always.
  function automatic logic [15:0] filt_write(input logic [15:0] cur, input logic [15:0] wd);
    logic [15:0] res;
    cfi_pkg::cfi_filt_s lo_c, hi_c;
    res = cur;
    lo_c = cur[cfi_pkg::HALF-1:0];
    hi_c = cur[2*cfi_pkg::HALF-1:cfi_pkg::HALF];
    if (!lo_c.en) begin
      res[cfi_pkg::HALF-1:0] = wd[cfi_pkg::HALF-1:0];
    end else begin
      res[cfi_pkg::F_EN] = wd[cfi_pkg::F_EN];
    end
    if (!hi_c.en) begin
      res[2*cfi_pkg::HALF-1:cfi_pkg::HALF] = wd[2*cfi_pkg::HALF-1:cfi_pkg::HALF];
    end else begin
      res[cfi_pkg::HALF+cfi_pkg::F_EN] = wd[cfi_pkg::HALF+cfi_pkg::F_EN];
    end
    filt_write = res;
  endfunction : filt_write

  assign addr_ok = mapped(HADDR[7:0]) && (HADDR[31:8] == 24'h000000);
  assign mode_hit = (CURRENT_OPERATING_MODE == req_r) && (mode_prev_r != req_r);

  // Bus slave: address phase is captured, writes land at the data phase, reads answer at once.
  always_comb begin
    st_nxt = st_r;
    wr_pend_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    rdata_nxt = rdata_r;
    ill_nxt = 1'b0;
    if (HSEL && HREADY && HTRANS[1]) begin
      st_nxt = cfi_pkg::ST_DATA;
      wr_addr_nxt = HADDR[7:0];
      wr_pend_nxt = HWRITE && addr_ok;
      ill_nxt = !addr_ok;
      rdata_nxt = 32'h00000000;
      if (!HWRITE) begin
        unique case (HADDR[7:0])
          cfi_pkg::OFF_CTRL: rdata_nxt = {16'h0000, on_r, 12'h000, req_r};
          cfi_pkg::OFF_FLAGS: rdata_nxt = {16'h0000, flags_r & cfi_pkg::FLAG_MASK};
          cfi_pkg::OFF_FLT4: rdata_nxt = {16'h0000, flt4_r};
          cfi_pkg::OFF_FLT5: rdata_nxt = {16'h0000, flt5_r};
          cfi_pkg::OFF_IEN: rdata_nxt = {16'h0000, ien_r};
          cfi_pkg::OFF_FIDX: rdata_nxt = {27'h0000000, FIFO_MESSAGE_INDEX};
          default: rdata_nxt = 32'h00000000;
        endcase
      end
    end else if (HREADY) begin
      st_nxt = cfi_pkg::ST_ADDR;
    end
  end

  // Register writes and flag logic; a hardware event always wins over a software clear.
  always_comb begin
    logic [15:0] wd;
    logic [15:0] set;
    wd = HWDATA[15:0];
    set = 16'h0000;
    on_nxt = on_r;
    req_nxt = req_r;
    ien_nxt = ien_r;
    flt4_nxt = flt4_r;
    flt5_nxt = flt5_r;
    flags_nxt = flags_r;
    if (wr_pend_r) begin
      unique case (wr_addr_r)
        cfi_pkg::OFF_CTRL: begin
          on_nxt = wd[cfi_pkg::B_ON];
          req_nxt = wd[cfi_pkg::MODE_LO +: 3];
        end
        cfi_pkg::OFF_FLAGS: flags_nxt = flags_r & (wd | ~cfi_pkg::SW_CLR_MASK);
        cfi_pkg::OFF_ICLR: flags_nxt = flags_r & ~(wd & cfi_pkg::SW_CLR_MASK);
        cfi_pkg::OFF_IEN: ien_nxt = wd & cfi_pkg::FLAG_MASK;
        cfi_pkg::OFF_FLT4: flt4_nxt = filt_write(flt4_r, wd);
        cfi_pkg::OFF_FLT5: flt5_nxt = filt_write(flt5_r, wd);
        default: flags_nxt = flags_r;
      endcase
    end
    // Turning the module off clears the sticky wake flag.
    if (on_r && !on_nxt) begin
      flags_nxt[cfi_pkg::B_WAKE] = 1'b0;
    end
    set[cfi_pkg::B_WAKE] = evt.wake;
    set[cfi_pkg::B_CERR] = evt.bus_err;
    set[cfi_pkg::B_SERR] = evt.sys_err || ill_r;
    set[cfi_pkg::B_OVF] = evt.rx_ovf;
    set[cfi_pkg::B_MOD] = mode_hit;
    set[cfi_pkg::B_TMR] = tmr_wrap;
    flags_nxt = flags_nxt | set;
    flags_nxt[cfi_pkg::B_RX] = evt.rx_pend;
    flags_nxt[cfi_pkg::B_TX] = evt.tx_pend;
  end

  // State registers.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      st_r <= cfi_pkg::ST_ADDR;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      ill_r <= 1'b0;
      rdata_r <= 32'h00000000;
      flags_r <= 16'h0000;
      ien_r <= 16'h0000;
      flt4_r <= 16'h0000;
      flt5_r <= 16'h0000;
      on_r <= 1'b0;
      req_r <= cfi_pkg::MODE_RST;
      mode_prev_r <= cfi_pkg::MODE_RST;
    end else begin
      st_r <= st_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      ill_r <= ill_nxt;
      rdata_r <= rdata_nxt;
      flags_r <= flags_nxt;
      ien_r <= ien_nxt;
      flt4_r <= flt4_nxt;
      flt5_r <= flt5_nxt;
      on_r <= on_nxt;
      req_r <= req_nxt;
      mode_prev_r <= CURRENT_OPERATING_MODE;
    end
  end

  // Outputs; the slave never waits and always answers OKAY.
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_r;
  assign REQUESTED_OPERATING_MODE = req_r;
  assign MODULE_ON = on_r;
  assign FILTER_CTRL4 = {16'h0000, flt4_r};
  assign FILTER_CTRL5 = {16'h0000, flt5_r};
  assign IRQ = |(flags_r & ien_r);

  // Checks. The flags sit behind one register stage, so each is looked at one edge after its cause; an illegal address takes two.
  chk_wake_sets: assert property (@(posedge CLK) disable iff (!NRST)
    WAKE_ACT |=> flags_r[cfi_pkg::B_WAKE]) else $error("wake flag not set");
  // Without activity the wake flag must not appear on its own.
  chk_wake_quiet: assert property (@(posedge CLK) disable iff (!NRST)
    !flags_r[cfi_pkg::B_WAKE] && !WAKE_ACT |=> !flags_r[cfi_pkg::B_WAKE])
    else $error("wake flag set without activity");
  chk_cerr_sets: assert property (@(posedge CLK) disable iff (!NRST)
    BUS_ERR |=> flags_r[cfi_pkg::B_CERR]) else $error("bus error flag not set");
  chk_serr_sets: assert property (@(posedge CLK) disable iff (!NRST)
    SYS_ERR |=> flags_r[cfi_pkg::B_SERR]) else $error("system error flag not set");
  chk_ovf_sets: assert property (@(posedge CLK) disable iff (!NRST)
    RX_OVF |=> flags_r[cfi_pkg::B_OVF]) else $error("overflow flag not set");
  // The mode check is written from the pins so that it does not lean on the internal edge detector.
  chk_mode_sets: assert property (@(posedge CLK) disable iff (!NRST)
    $past(NRST) && CURRENT_OPERATING_MODE == req_r && $past(CURRENT_OPERATING_MODE) != req_r
    |=> flags_r[cfi_pkg::B_MOD]) else $error("mode change flag not set");
  chk_tmr_sets: assert property (@(posedge CLK) disable iff (!NRST)
    tmr_wrap |=> flags_r[cfi_pkg::B_TMR]) else $error("timer overflow flag not set");
  chk_rx_follows: assert property (@(posedge CLK) disable iff (!NRST)
    ##1 flags_r[cfi_pkg::B_RX] == $past(RX_PEND)) else $error("rx pending wrong");
  chk_tx_follows: assert property (@(posedge CLK) disable iff (!NRST)
    ##1 flags_r[cfi_pkg::B_TX] == $past(TX_PEND)) else $error("tx pending wrong");
  chk_gap_zero: assert property (@(posedge CLK) disable iff (!NRST)
    flags_r[10:4] == 7'h00) else $error("unused flag bits set");
  // A read of the flag register must show nothing in the unused and upper positions.
  chk_flags_read: assert property (@(posedge CLK) disable iff (!NRST)
    HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR == {24'h000000, cfi_pkg::OFF_FLAGS}
    |=> HRDATA[31:15] == 17'h00000 && HRDATA[10:4] == 7'h00) else $error("flag read shows unused bits");
  chk_wake_sticky: assert property (@(posedge CLK) disable iff (!NRST)
    flags_r[cfi_pkg::B_WAKE] && on_r && $stable(on_r) ##1 on_r |-> flags_r[cfi_pkg::B_WAKE])
    else $error("wake flag cleared while on");
  // Switching the module off drops the wake flag unless new activity arrives in that same cycle.
  chk_off_clears: assert property (@(posedge CLK) disable iff (!NRST)
    $fell(on_r) && !$past(WAKE_ACT) |-> !flags_r[cfi_pkg::B_WAKE]) else $error("wake flag kept after off");
  // Every filter half keeps its mask and FIFO fields while it is enabled.
  chk_filt_lock: assert property (@(posedge CLK) disable iff (!NRST)
    flt4_r[cfi_pkg::F_EN] |=> flt4_r[cfi_pkg::F_EN-1:0] == $past(flt4_r[cfi_pkg::F_EN-1:0]))
    else $error("locked filter changed");
  chk_filt4_hi_lock: assert property (@(posedge CLK) disable iff (!NRST)
    flt4_r[cfi_pkg::HALF+cfi_pkg::F_EN] |=> flt4_r[cfi_pkg::HALF+cfi_pkg::F_EN-1:cfi_pkg::HALF] ==
    $past(flt4_r[cfi_pkg::HALF+cfi_pkg::F_EN-1:cfi_pkg::HALF])) else $error("locked upper filter changed");
  chk_filt5_lock: assert property (@(posedge CLK) disable iff (!NRST)
    flt5_r[cfi_pkg::F_EN] |=> flt5_r[cfi_pkg::F_EN-1:0] == $past(flt5_r[cfi_pkg::F_EN-1:0]))
    else $error("locked filter changed");
  chk_filt5_hi_lock: assert property (@(posedge CLK) disable iff (!NRST)
    flt5_r[cfi_pkg::HALF+cfi_pkg::F_EN] |=> flt5_r[cfi_pkg::HALF+cfi_pkg::F_EN-1:cfi_pkg::HALF] ==
    $past(flt5_r[cfi_pkg::HALF+cfi_pkg::F_EN-1:cfi_pkg::HALF])) else $error("locked upper filter changed");
  chk_ill_addr: assert property (@(posedge CLK) disable iff (!NRST)
    HSEL && HREADY && HTRANS[1] && !addr_ok |=> ##1 flags_r[cfi_pkg::B_SERR])
    else $error("illegal address not flagged");
  // An enabled overflow must reach the interrupt line on the edge after the event.
  chk_irq_level: assert property (@(posedge CLK) disable iff (!NRST)
    $past(NRST) && $past(RX_OVF) && ien_r[cfi_pkg::B_OVF] |-> IRQ) else $error("irq mismatch");
  // Without a write to the register file a set bus error flag never drops.
  chk_flag_holds: assert property (@(posedge CLK) disable iff (!NRST)
    flags_r[cfi_pkg::B_CERR] && !wr_pend_r |=> flags_r[cfi_pkg::B_CERR]) else $error("flag dropped by itself");
  chk_fidx_read: assert property (@(posedge CLK) disable iff (!NRST)
    HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR == {24'h000000, cfi_pkg::OFF_FIDX}
    |=> HRDATA == {27'h0000000, $past(FIFO_MESSAGE_INDEX)}) else $error("message index read wrong");
  cov_irq: cover property (@(posedge CLK) disable iff (!NRST) $rose(IRQ));
  cov_mode: cover property (@(posedge CLK) disable iff (!NRST) mode_hit);
  cov_wrap: cover property (@(posedge CLK) disable iff (!NRST) tmr_wrap);
  cov_lock: cover property (@(posedge CLK) disable iff (!NRST) wr_pend_r && flt5_r[cfi_pkg::F_EN]);
  // Back-to-back transfers: a new address phase while the previous data phase is on the bus.
  cov_back2back: cover property (@(posedge CLK) disable iff (!NRST)
    st_r == cfi_pkg::ST_DATA && HSEL && HREADY && HTRANS[1]);
endmodule : cfi_top

// ### cfi_tstamp.sv
// Timestamp timer that pulses on wrap.
`timescale 1ns/100ps
module cfi_tstamp #(
  parameter int W = cfi_pkg::TMR_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  output logic [W-1:0] count,
  output logic wrap
);
  logic [W-1:0] count_nxt;
  logic wrap_nxt;

  // Counting stops while the module is off so the wrap point stays predictable.
  always_comb begin
    count_nxt = count;
    wrap_nxt = 1'b0;
    if (run) begin
      count_nxt = count + {{(W-1){1'b0}}, 1'b1};
      wrap_nxt = &count;
    end
  end

  // Register stage.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      count <= '0;
      wrap <= 1'b0;
    end else begin
      count <= count_nxt;
      wrap <= wrap_nxt;
    end
  end
endmodule : cfi_tstamp

// ### tb_cfi_top.sv
// Self-checking testbench for the CAN flag and filter register block.
`timescale 1ns/100ps
module tb_cfi_top;
  localparam logic [7:0] A_CTL = cfi_pkg::OFF_CTRL;
  localparam logic [7:0] A_FL = cfi_pkg::OFF_FLAGS;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, fc4, fc5, r;
  logic hready, hresp, irq, mod_on;
  logic [2:0] req_mode, cur_mode;
  logic [3:0] ev;
  logic [1:0] pend;
  logic [4:0] idx;
  int n_fail = 0;
  int n_tests = 0;
  // Free-running 125 MHz clock.
  always #4 clk = ~clk;
  cfi_can_node u_node (.clk(clk), .nrst(nrst), .req_mode(req_mode), .ev(ev), .pend(pend), .cur_mode(cur_mode),
    .msg_index(idx));
  cfi_top u_dut (.CLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .WAKE_ACT(ev[3]), .BUS_ERR(ev[2]), .SYS_ERR(ev[1]), .RX_OVF(ev[0]), .RX_PEND(pend[1]), .TX_PEND(pend[0]),
    .CURRENT_OPERATING_MODE(cur_mode), .FIFO_MESSAGE_INDEX(idx), .REQUESTED_OPERATING_MODE(req_mode),
    .MODULE_ON(mod_on), .FILTER_CTRL4(fc4), .FILTER_CTRL5(fc5), .IRQ(irq));
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Bounded wait for hready at a rising edge; a bus that never answers ends the run.
  task automatic wait_rdy(input int lim);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < lim);
    if (hready !== 1'b1) begin
      n_fail++;
      complete_run();
    end
  endtask : wait_rdy
  // Single word transfer; the address phase is held until hready, read data taken at the data phase edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy(100);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(100);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rdc
  // IRQ is a level of registers, so it is sampled just after an edge.
  task automatic irqc(input logic exp);
    @(posedge clk);
    #1;
    chk({31'h0, irq}, {31'h0, exp});
  endtask : irqc
  task automatic t_reset();
    rdc(A_CTL, 32'h4);
    rdc(A_FL, 32'h0);
    rdc(cfi_pkg::OFF_FLT4, 32'h0);
    rdc(cfi_pkg::OFF_FLT5, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_events();
    for (int i = 3; i >= 0; i--) u_node.pulse(i);
    rdc(A_FL, 32'h7800);
    bus(1'b1, A_FL, 32'h0);
    rdc(A_FL, 32'h4000);
    bus(1'b1, cfi_pkg::OFF_ICLR, 32'h7800);
    rdc(A_FL, 32'h4000);
    bus(1'b1, A_CTL, 32'h8004);
    rdc(A_FL, 32'h4000);
    chk({31'h0, mod_on}, 32'h1);
    bus(1'b1, A_CTL, 32'h4);
    rdc(A_FL, 32'h0);
    chk({31'h0, mod_on}, 32'h0);
    $display("event test done");
  endtask : t_events
  task automatic t_pend();
    u_node.pend <= 2'h3;
    repeat (2) @(posedge clk);
    rdc(A_FL, 32'h3);
    u_node.pend <= 2'h0;
    repeat (2) @(posedge clk);
    rdc(A_FL, 32'h0);
    $display("pending test done");
  endtask : t_pend
  // A prompt and a slow mode change; the flag must wait for the reported mode.
  task automatic t_mode();
    for (int s = 0; s < 2; s++) begin
      u_node.lag = s ? 12 : 1;
      bus(1'b1, A_CTL, s ? 32'h8005 : 32'h8002);
      if (s) rdc(A_FL, 32'h0);
      repeat (16) @(posedge clk);
      rdc(A_FL, 32'h8);
      rdc(A_CTL, s ? 32'h8005 : 32'h8002);
      chk({29'h0, req_mode}, s ? 32'h5 : 32'h2);
      bus(1'b1, A_FL, 32'h0);
    end
    $display("mode test done");
  endtask : t_mode
  task automatic t_filter();
    logic [7:0] a;
    logic [31:0] v;
    for (int f = 0; f < 2; f++) begin
      a = f ? cfi_pkg::OFF_FLT5 : cfi_pkg::OFF_FLT4;
      for (int m = 0; m < 4; m++) begin
        v = {16'h0, 1'b0, 2'(m), 5'(31 - m), 1'b0, 2'(3 - m), 5'(m * 9)};
        bus(1'b1, a, v);
        rdc(a, v);
      end
      bus(1'b1, a, v | 32'h8080);
      rdc(a, v | 32'h8080);
      chk(f ? fc5 : fc4, v | 32'h8080);
      bus(1'b1, a, 32'h8080);
      rdc(a, v | 32'h8080);
      bus(1'b1, a, 32'h0);
      rdc(a, v);
    end
    $display("filter test done");
  endtask : t_filter
  task automatic t_irq();
    rdc(8'h1c, 32'h0);
    repeat (2) @(posedge clk);
    rdc(A_FL, 32'h1000);
    bus(1'b1, cfi_pkg::OFF_IEN, 32'h0800);
    irqc(1'b0);
    u_node.pulse(0);
    irqc(1'b1);
    bus(1'b1, cfi_pkg::OFF_ICLR, 32'h0800);
    irqc(1'b0);
    bus(1'b1, cfi_pkg::OFF_IEN, 32'h1000);
    irqc(1'b1);
    bus(1'b1, A_FL, 32'h0);
    rdc(A_FL, 32'h0);
    for (int i = 0; i < 2; i++) begin
      u_node.msg_index <= i ? 5'h1f : 5'h13;
      rdc(cfi_pkg::OFF_FIDX, i ? 32'h1f : 32'h13);
    end
    $display("interrupt test done");
  endtask : t_irq
  // The timer runs since the module was switched on; its wrap takes about 65536 cycles.
  task automatic t_timer();
    int k;
    bus(1'b1, cfi_pkg::OFF_IEN, 32'h4);
    for (k = 0; k < 70000 && irq !== 1'b1; k++) @(posedge clk);
    if (k >= 70000) begin
      n_fail++;
      complete_run();
    end
    rdc(A_FL, 32'h4);
    $display("timer test done");
  endtask : t_timer
  // Reset for 8 cycles, then each scenario in turn.
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_events();
    t_pend();
    t_mode();
    t_filter();
    t_irq();
    t_timer();
    complete_run();
  end
endmodule : tb_cfi_top
